// File: hdl/dmc_cfg.svh
/*
 holds offsets, field positions, range limits and timing counts for the
 motor channel command unit; assumes a 125 MHz clk_i.
*/
`ifndef DMC_CFG_SVH
`define DMC_CFG_SVH
`define DMC_CLK_MHZ 125
`define DMC_MS_CYCLES (`DMC_CLK_MHZ * 1000)
`define DMC_NCH 6
`define DMC_ADR_CMD 8'h00
`define DMC_ADR_ARG 8'h04
`define DMC_ADR_STAT 8'h08
`define DMC_ADR_CFG 8'h0C
`define DMC_ADR_SETPT 8'h10
`define DMC_ADR_FB 8'h30
`define DMC_CMD_OP_LSB 0
`define DMC_CMD_CH_LSB 4
`define DMC_CMD_VAL_LSB 8
`define DMC_ARG_VAL_LSB 0
`define DMC_ARG_DUR_LSB 16
`define DMC_POT_MAX 16'h0FFF
`define DMC_DUAL_MAX 16'h114C
`define DMC_ENC_MAX 16'h7FFF
`define DMC_SINGLE_DEG 332
`define DMC_MAXCH_SINGLE 3'h5
`define DMC_MAXCH_DUAL 3'h2
`define DMC_MAXCH_ENC 3'h1
`endif

// File: hdl/dmc_pkg.sv
/*
 types shared by the motor channel command unit; no surroundings assumed.
*/
package dmc_pkg;
  typedef enum logic [1:0] {
    DMC_FB_SINGLE = 2'h0,
    DMC_FB_DUAL = 2'h1,
    DMC_FB_ENC = 2'h2
  } dmc_fb_t;
  typedef enum logic [1:0] {
    DMC_LOOP_PWM = 2'h0,
    DMC_LOOP_POS = 2'h1,
    DMC_LOOP_VEL = 2'h2
  } dmc_loop_t;
  typedef enum logic [3:0] {
    DMC_OP_FB = 4'h1,
    DMC_OP_LOOP = 4'h2,
    DMC_OP_POS_T = 4'h3,
    DMC_OP_POS_I = 4'h4,
    DMC_OP_VEL_T = 4'h5,
    DMC_OP_VEL_I = 4'h6,
    DMC_OP_RESUME = 4'h7,
    DMC_OP_SUSPEND = 4'h8
  } dmc_op_t;
  typedef enum logic [2:0] {
    DMC_ST_IDLE = 3'h1,
    DMC_ST_EXEC = 3'h2,
    DMC_ST_ACK = 3'h4
  } dmc_st_t;
endpackage

// File: hdl/dmc_ramp.sv
/*
 one channel's setpoint generator: linear ramp over a millisecond period or
 an immediate jump; assumes commands arrive as one-cycle load pulses.
*/
`timescale 1ns/100ps
`default_nettype none
`include "dmc_cfg.svh"
module dmc_ramp #(
  parameter int MS_CYCLES = `DMC_MS_CYCLES
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // command
  input wire logic load_i,
  input wire logic [15:0] target_i,
  input wire logic [15:0] dur_ms_i,
  // state
  output logic [15:0] setpt_o,
  output logic busy_o
);
  logic [31:0] tick_q, tick_d;
  logic [15:0] left_q, left_d, tgt_q, tgt_d, sp_d;
  logic signed [17:0] diff;
  logic signed [17:0] step;
  logic ms_tick;

  assign ms_tick = (tick_q == 32'(MS_CYCLES - 1));
  assign diff = $signed({2'b00, tgt_q}) - $signed({2'b00, setpt_o});
  // equal share of the remaining distance per millisecond keeps it linear
  assign step = (left_q == 16'h0000) ? diff :
    18'(diff / $signed({2'b00, left_q}));

  always_comb begin
    tick_d = (busy_o && !ms_tick) ? tick_q + 32'h1 : 32'h0;
    left_d = left_q;
    tgt_d = tgt_q;
    sp_d = setpt_o;
    if (load_i) begin
      // a new command restarts from the present setpoint
      tgt_d = target_i;
      tick_d = 32'h0;
      if (dur_ms_i == 16'h0000) begin
        sp_d = target_i;
        left_d = 16'h0000;
      end else begin
        left_d = dur_ms_i;
      end
    end else if (busy_o && ms_tick) begin
      sp_d = 16'(setpt_o + step[15:0]);
      left_d = (left_q == 16'h0000) ? 16'h0000 : left_q - 16'h1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tick_q <= 32'h0;
      left_q <= 16'h0;
      tgt_q <= 16'h0;
      setpt_o <= 16'h0;
    end else begin
      tick_q <= tick_d;
      left_q <= left_d;
      tgt_q <= tgt_d;
      setpt_o <= sp_d;
    end
  end
  assign busy_o = (setpt_o != tgt_q);
endmodule // dmc_ramp
`default_nettype wire

// File: hdl/dmc_sync.sv
/*
 three-stage synchroniser with agreement filter for one pin input;
 assumes the pin is asynchronous to clk_i.
*/
`timescale 1ns/100ps
`default_nettype none
module dmc_sync (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // pin and result
  input wire logic pin_i,
  output logic level_o
);
  logic s1_q, s2_q, s3_q;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
      s3_q <= 1'b0;
      level_o <= 1'b0;
    end else begin
      s1_q <= pin_i;
      s2_q <= s1_q;
      s3_q <= s2_q;
      if (s2_q == s3_q) begin
        level_o <= s3_q;
      end
    end
  end
endmodule // dmc_sync
`default_nettype wire

// File: hdl/dmc_top.sv
/*
 motor channel command unit: wishbone command registers, per-channel
 feedback and loop selection, enables and setpoint ramps for six channels.
 assumes a classic wishbone master on clk_i and the pid/pwm stage outside.
*/
`timescale 1ns/100ps
`default_nettype none
`include "dmc_cfg.svh"
module dmc_top import dmc_pkg::*; #(
  parameter int NCH = `DMC_NCH,
  parameter int MS_CYCLES = `DMC_MS_CYCLES
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // pwm drive from the outer pid stage, gated here
  input wire logic [NCH-1:0] pwm_raw_i,
  output logic [NCH-1:0] pwm_o,
  // per channel state to the pid stage
  output logic [NCH-1:0] chan_en_o,
  output logic [2*NCH-1:0] feedback_sensor_select_o,
  output logic [2*NCH-1:0] loop_mode_select_o,
  output logic [16*NCH-1:0] setpoint_o,
  // potentiometer routing, primary and partner input index per channel
  output logic [3*NCH-1:0] pot_a_sel_o,
  output logic [3*NCH-1:0] pot_b_sel_o,
  // encoder index pins
  input wire logic [1:0] enc_index_i,
  output logic [1:0] enc_index_o
);
  localparam logic [2:0] NCH3 = 3'(NCH);

  dmc_st_t st_q, st_d;
  logic [31:0] arg_q, cmd_q, rdat;
  logic [1:0] fb_q [NCH];
  logic [1:0] loop_q [NCH];
  logic [NCH-1:0] en_q, load, busy;
  logic [15:0] sp [NCH];
  logic wb_req, wr_cmd, wr_arg;
  logic [3:0] op;
  logic [2:0] ch;
  logic [1:0] val2;
  logic [1:0] ch_fb;
  logic ch_ok, is_target, do_exec, vel_refused;
  logic [2:0] rd_idx;
  logic [7:0] setpt_off;

  // decode
  assign wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wr_cmd = wb_req && wb_we_i && (wb_adr_i == `DMC_ADR_CMD) &&
    (wb_sel_i == 4'hF);
  assign wr_arg = wb_req && wb_we_i && (wb_adr_i == `DMC_ADR_ARG);
  assign op = cmd_q[`DMC_CMD_OP_LSB +: 4];
  assign ch = cmd_q[`DMC_CMD_CH_LSB +: 3];
  assign val2 = cmd_q[`DMC_CMD_VAL_LSB +: 2];
  assign ch_fb = (ch < NCH3) ? fb_q[ch] : 2'h0;
  // legality of channel against its present feedback type
  assign ch_ok = (ch < NCH3) &&
    ((ch_fb == DMC_FB_SINGLE && ch <= `DMC_MAXCH_SINGLE) ||
     (ch_fb == DMC_FB_DUAL && ch <= `DMC_MAXCH_DUAL) ||
     (ch_fb == DMC_FB_ENC && ch <= `DMC_MAXCH_ENC));
  assign is_target = (op == DMC_OP_POS_T) || (op == DMC_OP_POS_I) ||
    (op == DMC_OP_VEL_T) || (op == DMC_OP_VEL_I);
  assign do_exec = (st_q == DMC_ST_EXEC) && ch_ok;
  // velocity target on single feedback is dropped whole, enable too
  assign vel_refused = ((op == DMC_OP_VEL_T) || (op == DMC_OP_VEL_I)) &&
    (ch_fb == DMC_FB_SINGLE);

  // command sequencer: take, execute, acknowledge
  always_comb begin
    case (st_q)
      DMC_ST_IDLE: st_d = wb_req ? (wr_cmd ? DMC_ST_EXEC : DMC_ST_ACK) :
        DMC_ST_IDLE;
      DMC_ST_EXEC: st_d = DMC_ST_ACK;
      DMC_ST_ACK: st_d = DMC_ST_IDLE;
      default: st_d = DMC_ST_IDLE;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_q <= DMC_ST_IDLE;
      cmd_q <= 32'h0;
      arg_q <= 32'h0;
    end else begin
      st_q <= st_d;
      if (wr_cmd) begin
        cmd_q <= wb_dat_i;
      end
      if (wr_arg) begin
        for (int b = 0; b < 4; b++) begin
          if (wb_sel_i[b]) begin
            arg_q[8*b +: 8] <= wb_dat_i[8*b +: 8];
          end
        end
      end
    end
  end

  // per channel configuration
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      for (int i = 0; i < NCH; i++) begin
        fb_q[i] <= DMC_FB_SINGLE;
        loop_q[i] <= DMC_LOOP_PWM;
      end
      en_q <= '0;
    end else if (do_exec) begin
      case (op)
        DMC_OP_FB: begin
          // codes above 2 and encoder beyond channel 1 are dropped
          if (val2 == DMC_FB_SINGLE ||
              (val2 == DMC_FB_DUAL && ch <= `DMC_MAXCH_DUAL) ||
              (val2 == DMC_FB_ENC && ch <= `DMC_MAXCH_ENC)) begin
            fb_q[ch] <= val2;
            // velocity cannot survive a move to single feedback
            if (val2 == DMC_FB_SINGLE && loop_q[ch] == DMC_LOOP_VEL) begin
              loop_q[ch] <= DMC_LOOP_PWM;
            end
          end
        end
        DMC_OP_LOOP: begin
          if (val2 != 2'h3 &&
              !(val2 == DMC_LOOP_VEL && ch_fb == DMC_FB_SINGLE)) begin
            loop_q[ch] <= val2;
          end
        end
        DMC_OP_RESUME: en_q[ch] <= 1'b1;
        DMC_OP_SUSPEND: en_q[ch] <= 1'b0;
        DMC_OP_POS_T, DMC_OP_POS_I, DMC_OP_VEL_T, DMC_OP_VEL_I: begin
          if (!vel_refused) begin
            en_q[ch] <= 1'b1;
          end
        end
        default: ;
      endcase
    end
  end

  // setpoint generators, one per channel
  // velocity values pass through unscaled; units follow feedback
  for (genvar g = 0; g < NCH; g++) begin : g_ch
    logic vel_single;
    assign vel_single = (op == DMC_OP_VEL_T || op == DMC_OP_VEL_I) &&
      (fb_q[g] == DMC_FB_SINGLE);
    assign load[g] = do_exec && is_target && (ch == 3'(g)) && !vel_single;
    dmc_ramp #(
      .MS_CYCLES(MS_CYCLES)
    ) u_ramp (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .load_i(load[g]),
      .target_i(arg_q[`DMC_ARG_VAL_LSB +: 16]),
      // immediate commands carry no period
      .dur_ms_i((op == DMC_OP_POS_T || op == DMC_OP_VEL_T) ?
        arg_q[`DMC_ARG_DUR_LSB +: 16] : 16'h0000),
      .setpt_o(sp[g]),
      .busy_o(busy[g])
    );
  end

  // encoder index pins pass the filter
  for (genvar e = 0; e < 2; e++) begin : g_enc
    logic lvl;
    dmc_sync u_sync (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .pin_i(enc_index_i[e]),
      .level_o(lvl)
    );
    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        enc_index_o[e] <= 1'b0;
      end else begin
        enc_index_o[e] <= lvl && (fb_q[e] == DMC_FB_ENC);
      end
    end
  end

  // registered outputs
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pwm_o <= '0;
      chan_en_o <= '0;
      feedback_sensor_select_o <= '0;
      loop_mode_select_o <= '0;
      setpoint_o <= '0;
      pot_a_sel_o <= '0;
      pot_b_sel_o <= '0;
    end else begin
      pwm_o <= pwm_raw_i & en_q;
      chan_en_o <= en_q;
      for (int i = 0; i < NCH; i++) begin
        feedback_sensor_select_o[2*i +: 2] <= fb_q[i];
        loop_mode_select_o[2*i +: 2] <= loop_q[i];
        setpoint_o[16*i +: 16] <= sp[i];
        pot_a_sel_o[3*i +: 3] <= 3'(i);
        // dual pairs mirror around the middle of the pot bank
        pot_b_sel_o[3*i +: 3] <= (fb_q[i] == DMC_FB_DUAL) ?
          3'(NCH - 1 - i) : 3'(i);
      end
    end
  end

  // read mux; unmapped addresses read zero
  assign setpt_off = wb_adr_i - `DMC_ADR_SETPT;
  assign rd_idx = setpt_off[4:2];
  always_comb begin
    rdat = 32'h0;
    if (wb_adr_i == `DMC_ADR_CMD) begin
      rdat = cmd_q;
    end else if (wb_adr_i == `DMC_ADR_ARG) begin
      rdat = arg_q;
    end else if (wb_adr_i == `DMC_ADR_STAT) begin
      rdat = {16'h0, 2'h0, busy, 2'h0, en_q};
    end else if (wb_adr_i == `DMC_ADR_CFG) begin
      for (int i = 0; i < NCH; i++) begin
        rdat[4*i +: 4] = {loop_q[i], fb_q[i]};
      end
    end else if (wb_adr_i >= `DMC_ADR_SETPT && wb_adr_i < `DMC_ADR_FB &&
                 wb_adr_i[1:0] == 2'h0 && rd_idx < NCH3) begin
      rdat = {16'h0, sp[rd_idx]};
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0;
    end else begin
      wb_ack_o <= (st_d == DMC_ST_ACK) && (st_q != DMC_ST_ACK);
      wb_dat_o <= rdat;
    end
  end

  // checks
  sequence s_target_taken;
    do_exec && is_target && !vel_refused && (ch < NCH3);
  endsequence
  a_target_enables: assert property (@(posedge clk_i) disable iff (rst_i)
    s_target_taken |=> en_q[$past(ch)])
    else $error("target command did not enable channel");
  a_pwm_gated: assert property (@(posedge clk_i) disable iff (rst_i)
    !$past(en_q[0]) |-> !pwm_o[0])
    else $error("pwm driven on suspended channel");
  a_enc_limited: assert property (@(posedge clk_i) disable iff (rst_i)
    fb_q[2] != DMC_FB_ENC)
    else $error("encoder on channel 2");
  a_vel_single: assert property (@(posedge clk_i) disable iff (rst_i)
    !(loop_q[0] == DMC_LOOP_VEL && fb_q[0] == DMC_FB_SINGLE))
    else $error("velocity with single pot");
  a_bad_chan_kept: assert property (@(posedge clk_i) disable iff (rst_i)
    (st_q == DMC_ST_EXEC && !ch_ok) |=> $stable(en_q))
    else $error("invalid channel changed state");
  a_vel_refused: assert property (@(posedge clk_i) disable iff (rst_i)
    (do_exec && vel_refused) |=> $stable(en_q))
    else $error("refused velocity command changed enables");
  a_suspend_clears: assert property (@(posedge clk_i) disable iff (rst_i)
    (do_exec && op == DMC_OP_SUSPEND) |=> !en_q[$past(ch)])
    else $error("suspend left channel enabled");
  a_dual_pair: assert property (@(posedge clk_i) disable iff (rst_i)
    $past(fb_q[1]) == DMC_FB_DUAL |-> pot_b_sel_o[5:3] == 3'h4)
    else $error("dual pair wrong on channel 1");
  a_imm_jump: assert property (@(posedge clk_i) disable iff (rst_i)
    (load[0] && op == DMC_OP_POS_I) |=> sp[0] == $past(arg_q[15:0]))
    else $error("immediate position not applied");
  a_ack_bound: assert property (@(posedge clk_i) disable iff (rst_i)
    (st_q == DMC_ST_IDLE && wb_req) |-> ##[1:2] wb_ack_o)
    else $error("wishbone ack late");
  a_ack_drop: assert property (@(posedge clk_i) disable iff (rst_i)
    wb_ack_o |=> !wb_ack_o)
    else $error("ack held two cycles");
endmodule // dmc_top
`default_nettype wire

// File: tb/dmc_motor_model.sv
/*
 motor side stand-in: raw pwm drive from the pid stage and encoder index
 pins; assumes the bench picks the index level it wants on each pin.
*/
`timescale 1ns/100ps
`default_nettype none
module dmc_motor_model (
  // bench control
  input wire logic [1:0] idx_lvl_i,
  // pins toward the unit
  output logic [5:0] pwm_raw_o,
  output logic [1:0] enc_index_o
);
  // pid asks full drive everywhere; gating is the unit's job
  assign pwm_raw_o = 6'h3F;
  assign enc_index_o = idx_lvl_i;
endmodule // dmc_motor_model
`default_nettype wire

// File: tb/testbench.sv
/*
 self-checking bench for the motor channel command unit over wishbone;
 assumes MS_CYCLES shrunk to 10 so a millisecond is ten clocks.
*/
`timescale 1ns/100ps
`default_nettype none
module testbench import dmc_pkg::*;;
  localparam int MS = 10;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [31:0] dat = 32'h0;
  logic [31:0] rd;
  logic [31:0] dat_o;
  logic ack;
  logic [5:0] raw, pwm, en;
  logic [11:0] fbs, lps;
  logic [95:0] sp;
  logic [17:0] pa, pb;
  logic [1:0] idx, idx_o;
  logic [1:0] lvl = 2'h0;
  int n_errors = 0;
  int checks = 0;
  int i;

  always #4 clk_i = ~clk_i;

  dmc_top #(.MS_CYCLES(MS)) dmc_top_inst (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(dat),
    .wb_dat_o(dat_o), .wb_ack_o(ack), .pwm_raw_i(raw), .pwm_o(pwm),
    .chan_en_o(en), .feedback_sensor_select_o(fbs),
    .loop_mode_select_o(lps), .setpoint_o(sp), .pot_a_sel_o(pa),
    .pot_b_sel_o(pb), .enc_index_i(idx), .enc_index_o(idx_o)
  );
  dmc_motor_model dmc_motor_model_inst (
    .idx_lvl_i(lvl), .pwm_raw_o(raw), .enc_index_o(idx)
  );

  task automatic check(input string name, input logic [31:0] seen,
                       input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("unexpected %s expected %0h seen %0h", name, exp, seen);
    end
  endtask

  // holds the request until ack is sampled, then releases for a cycle
  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
    int n;
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat <= d;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1 && n < 50);
    rd = dat_o;
    if (ack !== 1'b1) begin
      n_errors++;
      $display("unexpected ack at %0h expected 1 seen %0b", a, ack);
    end
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask

  task automatic cmd(input dmc_op_t op, input int ch,
                     input logic [1:0] code, input logic [15:0] tgt,
                     input logic [15:0] ms);
    xfer(1'b1, 8'h04, {ms, tgt});
    xfer(1'b1, 8'h00, {22'h0, code, 1'b0, ch[2:0], op});
    repeat (4) @(posedge clk_i);
  endtask

  task automatic complete_run;
    $display("checks %0d n_errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  initial begin
    repeat (5000) @(posedge clk_i);
    n_errors++;
    $display("unexpected watchdog expired");
    complete_run;
  end

  initial begin
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    xfer(1'b0, 8'h0C, 32'h0);
    check("cfg", rd, 32'h0);
    check("fb", {20'h0, fbs}, 32'h0);
    check("en", {26'h0, en}, 32'h0);
    check("pwm", {26'h0, pwm}, 32'h0);
    $display("test reset done");
    for (i = 0; i < 3; i++) begin
      cmd(DMC_OP_FB, 1, i[1:0], 16'h0, 16'h0);
      check("fb ch1", {30'h0, fbs[3:2]}, i);
    end
    for (i = 0; i < 3; i++) begin
      cmd(DMC_OP_FB, i, 2'h1, 16'h0, 16'h0);
      check("pot a", {29'h0, pa[3*i+:3]}, i);
      check("pot b", {29'h0, pb[3*i+:3]}, 5 - i);
    end
    cmd(DMC_OP_FB, 0, 2'h2, 16'h0, 16'h0);
    cmd(DMC_OP_FB, 2, 2'h2, 16'h0, 16'h0);
    check("enc ch2", {30'h0, fbs[5:4]}, 32'h1);
    cmd(DMC_OP_FB, 4, 2'h1, 16'h0, 16'h0);
    check("dual ch4", {30'h0, fbs[9:8]}, 32'h0);
    $display("test feedback done");
    for (i = 0; i < 3; i++) begin
      cmd(DMC_OP_LOOP, 1, i[1:0], 16'h0, 16'h0);
      check("loop ch1", {30'h0, lps[3:2]}, i);
    end
    cmd(DMC_OP_LOOP, 3, 2'h2, 16'h0, 16'h0);
    check("vel single", {30'h0, lps[7:6]}, 32'h0);
    $display("test loop done");
    cmd(DMC_OP_POS_I, 3, 2'h0, 16'h0FFF, 16'h0);
    check("en pos", {26'h0, en}, 32'h08);
    check("sp3", {16'h0, sp[63:48]}, 32'h0FFF);
    check("pwm3", {26'h0, pwm}, 32'h08);
    cmd(DMC_OP_POS_T, 4, 2'h0, 16'd100, 16'd4);
    xfer(1'b0, 8'h08, 32'h0);
    check("busy", {31'h0, rd[12]}, 32'h1);
    repeat (7) @(posedge clk_i);
    check("mid", {16'h0, sp[79:64]}, 32'd25);
    cmd(DMC_OP_POS_T, 4, 2'h0, 16'd16, 16'd2);
    check("restart", {31'h0, (sp[79:64] > 16)}, 32'h1);
    repeat (40) @(posedge clk_i);
    xfer(1'b0, 8'h20, 32'h0);
    check("sp4", {16'h0, rd[15:0]}, 32'd16);
    xfer(1'b0, 8'h08, 32'h0);
    check("idle", {18'h0, rd[13:8], 8'h0}, 32'h0);
    $display("test position done");
    cmd(DMC_OP_POS_I, 0, 2'h0, 16'h7FFF, 16'h0);
    check("sp0 pos", {16'h0, sp[15:0]}, 32'h7FFF);
    cmd(DMC_OP_VEL_I, 0, 2'h0, 16'h1234, 16'h0);
    check("sp0", {16'h0, sp[15:0]}, 32'h1234);
    cmd(DMC_OP_VEL_T, 1, 2'h0, 16'd40, 16'd2);
    repeat (30) @(posedge clk_i);
    check("sp1", {16'h0, sp[31:16]}, 32'd40);
    cmd(DMC_OP_VEL_I, 5, 2'h0, 16'd9, 16'h0);
    check("en vel", {26'h0, en}, 32'h1B);
    $display("test velocity done");
    cmd(DMC_OP_SUSPEND, 3, 2'h0, 16'h0, 16'h0);
    check("pwm susp", {28'h0, pwm[3:0]}, 32'h3);
    cmd(DMC_OP_POS_I, 6, 2'h0, 16'h0010, 16'h0);
    check("bad ch", {26'h0, en}, 32'h13);
    xfer(1'b0, 8'hFC, 32'h0);
    check("unmapped", rd, 32'h0);
    lvl <= 2'h3;
    repeat (8) @(posedge clk_i);
    check("index", {30'h0, idx_o}, 32'h1);
    $display("test misc done");
    complete_run;
  end
endmodule // testbench
`default_nettype wire
